// ### design/fpws_array.sv
// flash plane storage with erase and zero-only programming
// assumes one write op per cycle from the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fpws_cfg.svh"
module fpws_array #(
  parameter int WORDS = `FPWS_NP * `FPWS_PW,
  parameter int AW = `FPWS_FAW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] op,
  input wire logic [AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [31:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [31:0] rdata_b
);
  import fpws_pkg::*;
  logic [31:0] mem_q [WORDS];
  logic [31:0] prev_q;
  logic [AW-1:0] pa_q;
  logic [1:0] pop_q;

  // ========================================
  // storage
  always_ff @(posedge pclk)
  begin
    if (op == `FPWS_OP_ERASE)
      mem_q[waddr] <= '1;
    else if (op == `FPWS_OP_PROG)
      mem_q[waddr] <= mem_q[waddr] & wdata;
  end

  assign rdata_a = mem_q[raddr_a];
  assign rdata_b = mem_q[raddr_b];

  // ========================================
  // checks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q <= '0;
      pa_q <= '0;
      pop_q <= `FPWS_OP_NONE;
    end
    else
    begin
      prev_q <= mem_q[waddr];
      pa_q <= waddr;
      pop_q <= op;
    end
  end

  property p_zero_only;
    @(posedge pclk) disable iff (!presetn)
    pop_q == `FPWS_OP_PROG |-> (mem_q[pa_q] & ~prev_q) == 32'h0;
  endproperty
  a_zero_only: assert property (p_zero_only)
    else $error("programming raised a bit to one");

  property p_erase_ones;
    @(posedge pclk) disable iff (!presetn)
    pop_q == `FPWS_OP_ERASE |-> mem_q[pa_q] == 32'hffffffff;
  endproperty
  a_erase_ones: assert property (p_erase_ones)
    else $error("erased word not all ones");
endmodule
`default_nettype wire

// ### design/fpws_cfg.svh
// constants of the flash page write sequencer
// assumes a 32-bit apb slave on one 50 mhz clock
`ifndef FPWS_CFG_SVH
`define FPWS_CFG_SVH
// ========================================
// geometry
`define FPWS_AW 16
`define FPWS_PW 8
`define FPWS_WIX 3
`define FPWS_NP 16
`define FPWS_PGW 4
`define FPWS_NL 4
`define FPWS_LKW 2
`define FPWS_FAW 7
// ========================================
// register byte offsets, latch window on top bit
`define FPWS_REG_MODE 16'h0000
`define FPWS_REG_CMD 16'h0004
`define FPWS_REG_STAT 16'h0008
`define FPWS_REG_LOCK 16'h000c
`define FPWS_WIN_BIT 15
// ========================================
// fields
`define FPWS_KEY_LSB 24
`define FPWS_KEY 8'ha5
`define FPWS_ARG_LSB 8
`define FPWS_CNT_LSB 16
`define FPWS_FWS_LSB 8
`define FPWS_FWS_RST 4'h0
`define FPWS_ST_RDY 0
`define FPWS_ST_CERR 1
`define FPWS_ST_LERR 2
`define FPWS_ST_FERR 3
// ========================================
// command codes
`define FPWS_C_WP 8'h01
`define FPWS_C_WRLK 8'h02
`define FPWS_C_ERWR 8'h03
`define FPWS_C_ERWRLK 8'h04
`define FPWS_C_EA 8'h05
`define FPWS_C_EPA 8'h06
`define FPWS_C_SLB 8'h08
`define FPWS_C_CLB 8'h09
// array operations
`define FPWS_OP_NONE 2'h0
`define FPWS_OP_ERASE 2'h1
`define FPWS_OP_PROG 2'h2
`endif

// ### design/fpws_pkg.sv
// types of the flash page write sequencer
// assumes fpws_cfg.svh on the include path
`include "fpws_cfg.svh"
package fpws_pkg;
  // ========================================
  // apb carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`FPWS_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } fpws_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fpws_apb_rsp_t;
  // ========================================
  // sequencer
  typedef enum logic [2:0] {
    ST_IDLE, ST_ERASE, ST_PROG, ST_VERIFY, ST_DONE
  } fpws_st_t;
  typedef enum logic [2:0] {
    SEL_MODE, SEL_CMD, SEL_STAT, SEL_LOCK, SEL_WIN, SEL_BAD
  } fpws_sel_t;
  typedef struct packed {
    fpws_st_t st;
    logic [7:0] cmd;
    logic [`FPWS_PGW-1:0] tpage;
    logic [`FPWS_PGW-1:0] epage;
    logic [`FPWS_PGW:0] ecnt;
    logic [`FPWS_WIX-1:0] widx;
    logic [`FPWS_NL-1:0] locks;
    logic ready;
    logic cmd_err;
    logic lock_err;
    logic fl_err;
    logic irq_en;
    logic irq;
    logic [3:0] fws;
    logic [3:0] wcnt;
    fpws_apb_rsp_t rsp;
  } fpws_state_t;
endpackage

// ### design/fpws_top.sv
// flash page write sequencer with apb registers and page latch
// assumes an apb master on pclk and word writes to the latch
`timescale 1ns/1ps
`default_nettype none
`include "fpws_cfg.svh"
module fpws_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire fpws_pkg::fpws_apb_req_t apb_req,
  output fpws_pkg::fpws_apb_rsp_t apb_rsp,
  output logic irq
);
  import fpws_pkg::*;
  fpws_state_t s;
  fpws_state_t n;
  logic [31:0] latch_q [`FPWS_PW];
  logic lwe;
  logic lfill;
  logic [1:0] aop;
  logic [`FPWS_FAW-1:0] aaddr;
  logic [31:0] adata;
  logic [31:0] vdata;
  logic [31:0] wdata_rd;
  logic setup;
  logic acc;
  fpws_sel_t sel;
  logic [7:0] code;
  logic [`FPWS_PGW-1:0] apg;
  logic [`FPWS_PGW:0] acnt;
  logic key_ok;
  logic [`FPWS_WIX-1:0] lidx;

  // ========================================
  // helpers
  function automatic fpws_sel_t dec(input logic [`FPWS_AW-1:0] a);
    if (a[`FPWS_WIN_BIT])
      return SEL_WIN;
    case (a)
      `FPWS_REG_MODE: return SEL_MODE;
      `FPWS_REG_CMD: return SEL_CMD;
      `FPWS_REG_STAT: return SEL_STAT;
      `FPWS_REG_LOCK: return SEL_LOCK;
      default: return SEL_BAD;
    endcase
  endfunction

  function automatic logic [`FPWS_LKW-1:0] region(
    input logic [`FPWS_PGW-1:0] pg);
    return pg[`FPWS_PGW-1 -: `FPWS_LKW];
  endfunction

  function automatic logic is_prog(input logic [7:0] c);
    return c == `FPWS_C_WP || c == `FPWS_C_WRLK ||
      c == `FPWS_C_ERWR || c == `FPWS_C_ERWRLK;
  endfunction

  function automatic logic is_lockc(input logic [7:0] c);
    return c == `FPWS_C_WRLK || c == `FPWS_C_ERWRLK;
  endfunction

  assign setup = apb_req.psel && !apb_req.penable;
  assign acc = apb_req.psel && apb_req.penable && s.rsp.pready;
  assign sel = dec(apb_req.paddr);
  assign code = apb_req.pwdata[7:0];
  assign apg = apb_req.pwdata[`FPWS_ARG_LSB +: `FPWS_PGW];
  assign acnt = apb_req.pwdata[`FPWS_CNT_LSB +: `FPWS_PGW+1];
  assign key_ok = apb_req.pwdata[`FPWS_KEY_LSB +: 8] == `FPWS_KEY;
  assign lidx = apb_req.paddr[`FPWS_WIX+1:2];

  // ========================================
  // next state
  always_comb
  begin
    n = s;
    aop = `FPWS_OP_NONE;
    aaddr = {s.tpage, s.widx};
    adata = 32'hffffffff;
    lwe = 1'b0;
    lfill = 1'b0;
    n.rsp.pready = 1'b0;
    if (setup)
    begin
      n.wcnt = (sel == SEL_WIN && apb_req.pwrite) ? s.fws : 4'h0;
      n.rsp.pready = n.wcnt == 4'h0;
      n.rsp.pslverr = sel == SEL_BAD || (sel == SEL_WIN &&
        apb_req.pwrite && apb_req.pstrb != 4'hf);
      unique case (sel)
        SEL_MODE: n.rsp.prdata = {20'h0, s.fws, 7'h0, s.irq_en};
        SEL_STAT: n.rsp.prdata = {28'h0, s.fl_err, s.lock_err,
          s.cmd_err, s.ready};
        SEL_LOCK: n.rsp.prdata = {{(32-`FPWS_NL){1'b0}}, s.locks};
        SEL_WIN: n.rsp.prdata = wdata_rd;
        default: n.rsp.prdata = 32'h0;
      endcase
    end
    else if (apb_req.psel && apb_req.penable && !s.rsp.pready)
    begin
      n.wcnt = s.wcnt - 4'h1;
      n.rsp.pready = s.wcnt == 4'h1;
    end
    if (acc && !s.rsp.pslverr && !apb_req.pwrite && sel == SEL_STAT)
    begin
      n.cmd_err = 1'b0;
      n.lock_err = 1'b0;
      n.fl_err = 1'b0;
    end
    if (acc && !s.rsp.pslverr && apb_req.pwrite)
    begin
      if (sel == SEL_MODE)
      begin
        n.irq_en = apb_req.pwdata[0];
        n.fws = apb_req.pwdata[`FPWS_FWS_LSB +: 4];
      end
      if (sel == SEL_WIN)
        lwe = 1'b1;
      if (sel == SEL_CMD && !key_ok)
        n.cmd_err = 1'b1;
      if (sel == SEL_CMD && key_ok && s.ready && s.st == ST_IDLE)
      begin
        n.ready = 1'b0;
        n.cmd = code;
        n.tpage = apg;
        n.epage = apg;
        n.widx = '0;
        n.st = ST_DONE;
        case (code)
          `FPWS_C_WP, `FPWS_C_WRLK:
            if (s.locks[region(apg)])
              n.lock_err = 1'b1;
            else
              n.st = ST_PROG;
          `FPWS_C_ERWR, `FPWS_C_ERWRLK:
            if (s.locks[region(apg)])
              n.lock_err = 1'b1;
            else
            begin
              n.ecnt = (`FPWS_PGW+1)'(1);
              n.st = ST_ERASE;
            end
          `FPWS_C_EA:
            if (|s.locks)
              n.lock_err = 1'b1;
            else
            begin
              n.epage = '0;
              n.ecnt = (`FPWS_PGW+1)'(`FPWS_NP);
              n.st = ST_ERASE;
            end
          `FPWS_C_EPA:
          begin
            n.ecnt = acnt;
            if (acnt != '0)
              n.st = ST_ERASE;
          end
          `FPWS_C_SLB: n.locks[region(apg)] = 1'b1;
          `FPWS_C_CLB: n.locks[region(apg)] = 1'b0;
          default: n.cmd_err = 1'b1;
        endcase
      end
    end
    unique case (s.st)
      ST_IDLE:
      begin
      end
      ST_ERASE:
        if (s.locks[region(s.epage)])
        begin
          n.lock_err = 1'b1;
          n.st = ST_DONE;
        end
        else
        begin
          aop = `FPWS_OP_ERASE;
          aaddr = {s.epage, s.widx};
          n.widx = s.widx + 1'b1;
          if (&s.widx)
          begin
            n.epage = s.epage + 1'b1;
            n.ecnt = s.ecnt - 1'b1;
            if (s.ecnt == (`FPWS_PGW+1)'(1))
              n.st = is_prog(s.cmd) ? ST_PROG : ST_DONE;
          end
        end
      ST_PROG:
      begin
        aop = `FPWS_OP_PROG;
        adata = latch_q[s.widx];
        n.widx = s.widx + 1'b1;
        if (&s.widx)
          n.st = ST_VERIFY;
      end
      ST_VERIFY:
      begin
        if ((vdata & ~latch_q[s.widx]) != 32'h0)
          n.fl_err = 1'b1;
        n.widx = s.widx + 1'b1;
        if (&s.widx)
        begin
          if (is_lockc(s.cmd))
            n.locks[region(s.tpage)] = 1'b1;
          n.st = ST_DONE;
        end
      end
      ST_DONE:
      begin
        n.ready = 1'b1;
        lfill = is_prog(s.cmd);
        n.st = ST_IDLE;
      end
    endcase
    n.irq = n.ready && n.irq_en;
  end

  // ========================================
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ready <= 1'b1;
      s.fws <= `FPWS_FWS_RST;
    end
    else
      s <= n;
  end

  // latch has no reset: contents undefined at power-up
  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < `FPWS_PW; i++)
      if (lfill)
        latch_q[i] <= 32'hffffffff;
      else if (lwe && lidx == i[`FPWS_WIX-1:0])
        latch_q[i] <= apb_req.pwdata;
  end

  fpws_array u_array (
    .pclk(pclk),
    .presetn(presetn),
    .op(aop),
    .waddr(aaddr),
    .wdata(adata),
    .raddr_a({s.tpage, s.widx}),
    .rdata_a(vdata),
    .raddr_b(apb_req.paddr[`FPWS_FAW+1:2]),
    .rdata_b(wdata_rd)
  );

  assign apb_rsp = s.rsp;
  assign irq = s.irq;

  // ========================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic cmd_wr;
  assign cmd_wr = acc && apb_req.pwrite && sel == SEL_CMD;

  property p_cmd_clr;
    cmd_wr && key_ok && s.ready && s.st == ST_IDLE |=> !s.ready;
  endproperty
  a_cmd_clr: assert property (p_cmd_clr)
    else $error("ready not cleared by command");

  property p_bad_key;
    cmd_wr && !key_ok |=> s.cmd_err;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("bad key not flagged");

  property p_busy;
    cmd_wr && !s.ready |=> $stable(s.cmd) && $stable(s.tpage);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy command disturbed sequence");

  property p_irq;
    $rose(s.ready) && s.irq_en |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing on ready");

  property p_no_locked_op;
    aop != `FPWS_OP_NONE |-> !s.locks[region(aaddr[`FPWS_FAW-1 -:
      `FPWS_PGW])];
  endproperty
  a_no_locked_op: assert property (p_no_locked_op)
    else $error("locked page modified");

  property p_lock_err;
    cmd_wr && key_ok && s.ready && s.st == ST_IDLE && is_prog(code) &&
      s.locks[region(apg)] |=> s.lock_err ##1 s.ready;
  endproperty
  a_lock_err: assert property (p_lock_err)
    else $error("locked target not flagged");

  property p_refill;
    s.st == ST_DONE && is_prog(s.cmd) |=> latch_q[0] == 32'hffffffff &&
      latch_q[`FPWS_PW-1] == 32'hffffffff;
  endproperty
  a_refill: assert property (p_refill)
    else $error("latch not refilled");

  sequence s_win_setup2;
    setup && sel == SEL_WIN && apb_req.pwrite && s.fws == 4'h2;
  endsequence
  sequence s_two_waits;
    !apb_rsp.pready [*2] ##1 apb_rsp.pready;
  endsequence
  property p_wait;
    s_win_setup2 |=> s_two_waits;
  endproperty
  a_wait: assert property (p_wait)
    else $error("latch write wait states wrong");

  property p_one_page;
    aop == `FPWS_OP_PROG |-> aaddr[`FPWS_FAW-1 -: `FPWS_PGW] == s.tpage;
  endproperty
  a_one_page: assert property (p_one_page)
    else $error("program left target page");

  property p_ready_back;
    s.st == ST_VERIFY && &s.widx |=> ##1 s.ready;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready not restored");
endmodule
`default_nettype wire

// ### sim/flash_page_write_sequencer_test.sv
// bench of the page write sequencer, apb tasks and checks
// assumes fws set to 2 before any latch write
`timescale 1ns/1ps
`default_nettype none
`include "fpws_cfg.svh"
module flash_page_write_sequencer_test;
  import fpws_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  fpws_apb_req_t req;
  fpws_apb_rsp_t rsp;
  logic irq;
  logic i0;
  logic [31:0] st;
  logic [31:0] st0;
  int n_mismatch = 0;
  int comparisons = 0;
  always #10 pclk = ~pclk;
  fpws_host host (.pclk(pclk), .req(req), .rsp(rsp));
  fpws_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .irq(irq));
  // ========================================
  // checks and bus tasks
  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic be, input int cyc,
    output logic [31:0] r);
    logic e;
    int n;
    host.xfer(w, a, d, r, e, n);
    chk("pslverr", {31'h0, be}, {31'h0, e});
    chk("wait", cyc, n);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, 1'b0, a[15] ? 3 : 1, r);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp,
    input string nm);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, 1'b0, 1, r);
    chk(nm, exp, r);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [3:0] pg,
    input logic [7:0] k);
    wr(`FPWS_REG_CMD, {k, 8'h01, 4'h0, pg, c});
  endtask
  // whole latch, padded with ones, contiguous order
  task automatic fill(input logic [3:0] pg, input logic [31:0] d0,
    input logic [31:0] d1, input logic dsc);
    logic [2:0] i;
    for (int j = 0; j < 8; j++)
    begin
      i = dsc ? 3'(7 - j) : 3'(j);
      wr(16'h8000 | {pg, i, 2'b00},
        i == 0 ? d0 : (i == 1 ? d1 : 32'hffffffff));
    end
  endtask
  // polls status, gathers every flag seen
  task automatic wait_rdy();
    logic [31:0] r;
    logic e;
    int n;
    r = 32'h0;
    st = 32'h0;
    @(posedge pclk);
    for (int t = 0; t < 100 && r[0] !== 1'b1; t++)
    begin
      host.xfer(1'b0, `FPWS_REG_STAT, 32'h0, r, e, n);
      if (t == 0)
      begin
        st0 = r;
        i0 = irq;
      end
      st = st | r;
    end
    st = {28'h0, st[3:0]};
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ========================================
  // tests
  initial
  begin
    #400000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`FPWS_REG_STAT, 32'h1, "ready");
    rd(`FPWS_REG_LOCK, 32'h0, "locks");
    acc(1'b0, 16'h0010, 32'h0, 1'b1, 1, st);
    wr(`FPWS_REG_MODE, 32'h00000201);
    fill(4'd2, 32'h00005555, 32'h12345678, 1'b0);
    cmd(`FPWS_C_ERWR, 4'd2, `FPWS_KEY);
    wait_rdy();
    chk("busy", 32'h0, {31'h0, st0[0]});
    chk("irq_busy", 32'h0, {31'h0, i0});
    chk("status", 32'h1, st);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(16'h8044, 32'h12345678, "ewp");
    fill(4'd9, 32'hffffffff, 32'hff00ff00, 1'b1);
    cmd(`FPWS_C_WP, 4'd2, `FPWS_KEY);
    wait_rdy();
    rd(16'h8044, 32'h12005600, "zeros");
    rd(16'h8040, 32'h00005555, "partial");
    cmd(`FPWS_C_ERWR, 4'd3, `FPWS_KEY);
    wait_rdy();
    rd(16'h8064, 32'hffffffff, "refill");
    fill(4'd0, 32'hffffffff, 32'h000000ff, 1'b0);
    cmd(`FPWS_C_ERWRLK, 4'd2, `FPWS_KEY);
    wait_rdy();
    rd(16'h8044, 32'h000000ff, "erase_write_page_lock_cmd");
    rd(`FPWS_REG_LOCK, 32'h1, "lock");
    cmd(`FPWS_C_WP, 4'd3, `FPWS_KEY);
    wait_rdy();
    chk("lock_err", 32'h5, st);
    cmd(`FPWS_C_EPA, 4'd1, `FPWS_KEY);
    wait_rdy();
    chk("erase_locked", 32'h5, st);
    cmd(`FPWS_C_SLB, 4'd12, `FPWS_KEY);
    wait_rdy();
    rd(`FPWS_REG_LOCK, 32'h9, "set_lock");
    cmd(`FPWS_C_CLB, 4'd0, `FPWS_KEY);
    wait_rdy();
    rd(`FPWS_REG_LOCK, 32'h8, "clear_lock");
    cmd(`FPWS_C_EPA, 4'd2, `FPWS_KEY);
    wait_rdy();
    rd(16'h8044, 32'hffffffff, "epa");
    fill(4'd2, 32'hffffffff, 32'h0f000000, 1'b0);
    cmd(`FPWS_C_WRLK, 4'd2, `FPWS_KEY);
    wait_rdy();
    rd(16'h8044, 32'h0f000000, "wpl");
    rd(`FPWS_REG_LOCK, 32'h9, "wpl_lock");
    cmd(`FPWS_C_EA, 4'd0, `FPWS_KEY);
    wait_rdy();
    chk("ea_locked", 32'h5, st);
    cmd(`FPWS_C_WP, 4'd6, 8'h5a);
    wait_rdy();
    chk("cmd_err", 32'h3, st);
    cmd(8'h07, 4'd6, `FPWS_KEY);
    wait_rdy();
    chk("bad_code", 32'h3, st);
    cmd(`FPWS_C_ERWR, 4'd6, `FPWS_KEY);
    cmd(`FPWS_C_WP, 4'd6, `FPWS_KEY);
    wait_rdy();
    chk("ignored", 32'h1, st);
    close_out();
  end
endmodule
`default_nettype wire

// ### sim/fpws_host.sv
// apb requester model standing for the processor core
// assumes fpws_pkg compiled first; one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module fpws_host (
  input wire logic pclk,
  output var fpws_pkg::fpws_apb_req_t req,
  input wire fpws_pkg::fpws_apb_rsp_t rsp
);
  import fpws_pkg::*;
  initial
  begin
    req = '0;
  end
  // ========================================
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e,
    output int n);
    n = 0;
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= 4'hf;
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    req.pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire
